/* verif/mioprt_board.sv */
// Board circuitry on the port pads: pull-ups and external drivers.
`timescale 1ns/10ps

module mioprt_board (
  // Pads from the unit.
  input wire logic [7:0] p1PadOut,
  input wire logic [7:0] p1PadOe,
  input wire logic [7:0] p2PadOut,
  input wire logic [7:0] p2PadOe,
  input wire logic [5:0] p3PadOut,
  input wire logic [5:0] p3PadOe,
  // External drivers.
  input wire logic [7:0] extVal2,
  input wire logic [7:0] extEn2,
  // Levels back to the unit.
  output logic [7:0] p1PadIn,
  output logic [7:0] p2PadIn,
  output logic [5:0] p3PadIn
);
  // Every pad has a pull-up, so a floating pin reads high rather than a stale level.
  assign p1PadIn = (p1PadOe & p1PadOut) | ~p1PadOe;
  assign p2PadIn = (p2PadOe & p2PadOut) | (~p2PadOe & extEn2 & extVal2) | (~p2PadOe & ~extEn2);
  assign p3PadIn = (p3PadOe & p3PadOut) | ~p3PadOe;
endmodule

/* verif/mioprt_chk.sv */
// Port-level checker for the multiplexed I/O port unit.
`timescale 1ns/10ps

`include "mioprt_regs.svh"

module mioprt_chk #(
  parameter int P1_W = 8,
  parameter int P2_W = 8,
  parameter int P3_W = 6
) (
  // Clock and control.
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Register port.
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [`MIOPRT_DATA_W-1:0] regRdData,
  // Peripheral side.
  input wire logic serial0RxOe,
  input wire logic serial1RxOe,
  input wire logic serial0_clear_to_send,
  input wire logic serial1RxIn,
  // Pads.
  input wire logic [P1_W-1:0] p1PadOe,
  input wire logic [P2_W-1:0] p2PadIn,
  input wire logic [P2_W-1:0] p2PadOe,
  input wire logic [P3_W-1:0] p3PadOut,
  input wire logic [P3_W-1:0] p3PadOe
);
  // ****
  // Properties on the single clock domain.
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Output-only pins never release their drivers.
  a_p1_drive_all: assert property (p1PadOe == {P1_W{1'b1}}) else $error("p1 driver off");
  a_p3_low_drive: assert property (p3PadOe[3:0] == 4'hF) else $error("p3 low driver off");
  // Open-drain pins can only pull low.
  a_od_out_low: assert property (p3PadOut[5:4] == 2'b00) else $error("open-drain drives high");
  // Read data stands only in the cycle after a strobe.
  a_rd_idle_zero: assert property (!$past(regRdEn) && $past(clkEn) |-> regRdData == 16'h0000)
    else $error("read data without strobe");
  // Open-drain enables move only after a register write.
  a_od_oe_cause: assert property ($changed(p3PadOe[5:4]) |-> $past(rst) || $past(regWrEn))
    else $error("open-drain enable moved alone");
  // Port 2 enables follow writes or the receive-line enables.
  a_p2_oe_cause: assert property ($changed(p2PadOe) |-> $past(rst) || $past(regWrEn) ||
    $changed(serial0RxOe) || $changed(serial1RxOe)) else $error("p2 enable moved alone");
  // Peripheral inputs see the pin two enabled edges late.
  a_sync_serial0_clear_to_send: assert property ($past(clkEn) && $past(clkEn, 2) && !$past(rst) && !$past(rst, 2) |->
    serial0_clear_to_send == $past(p2PadIn[3], 2)) else $error("serial0_clear_to_send level wrong");
  a_sync_rx1: assert property ($past(clkEn) && $past(clkEn, 2) && !$past(rst) && !$past(rst, 2) |->
    serial1RxIn == $past(p2PadIn[4], 2)) else $error("rx1 level wrong");
endmodule

bind mioprt_port_unit mioprt_chk #(.P1_W(P1_W), .P2_W(P2_W), .P3_W(P3_W)) uChk (.clk(clk), .rst(rst),
  .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .serial0RxOe(serial0RxOe),
  .serial1RxOe(serial1RxOe), .serial0_clear_to_send(serial0_clear_to_send), .serial1RxIn(serial1RxIn),
  .p1PadOe(p1PadOe), .p2PadIn(p2PadIn), .p2PadOe(p2PadOe), .p3PadOut(p3PadOut), .p3PadOe(p3PadOe));

/* verif/testbench.sv */
// Self-checking testbench for the multiplexed I/O port unit.
`timescale 1ns/10ps

module testbench;
  logic clk, rst, clkEn, regWrEn, regRdEn;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic [7:0] general_chip_selects, p1PadIn, p1PadOut, p1PadOe, p2PadIn, p2PadOut, p2PadOe, extVal2, extEn2;
  logic [5:0] p3PadIn, p3PadOut, p3PadOe;
  logic [3:0] irq;
  logic s1Tx, s1Rx, s1RxOe, s0Tx, s0Rx, s0RxOe, s1Cts, s1Bclk, s1RxIn, s0Cts, s0Bclk, s0RxIn;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  mioprt_port_unit dut (.clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .general_chip_selects(general_chip_selects),
    .serial1_clear_to_send(s1Cts), .serial1_baud_clock_in(s1Bclk), .serial1_transmit_line(s1Tx),
    .serial1_receive_line(s1Rx), .serial1RxOe(s1RxOe), .serial1RxIn(s1RxIn), .serial0_clear_to_send(s0Cts),
    .serial0_baud_clock_in(s0Bclk), .serial0_transmit_line(s0Tx), .serial0_receive_line(s0Rx),
    .serial0RxOe(s0RxOe), .serial0RxIn(s0RxIn), .serial1_receive_interrupt(irq[0]),
    .serial1_transmit_interrupt(irq[1]), .dma0_interrupt_request(irq[2]), .dma1_interrupt_request(irq[3]),
    .p1PadIn(p1PadIn), .p1PadOut(p1PadOut), .p1PadOe(p1PadOe), .p2PadIn(p2PadIn), .p2PadOut(p2PadOut),
    .p2PadOe(p2PadOe), .p3PadIn(p3PadIn), .p3PadOut(p3PadOut), .p3PadOe(p3PadOe));
  mioprt_board board (.p1PadOut(p1PadOut), .p1PadOe(p1PadOe), .p2PadOut(p2PadOut), .p2PadOe(p2PadOe),
    .p3PadOut(p3PadOut), .p3PadOe(p3PadOe), .extVal2(extVal2), .extEn2(extEn2), .p1PadIn(p1PadIn),
    .p2PadIn(p2PadIn), .p3PadIn(p3PadIn));

  // ****
  // Clock, watchdog and shared tasks.
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hung run is cut short well past the hundred or so cycles the tests need.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask

  // Read data is taken one cycle after the strobe, the only cycle it stands.
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****
  // Main sequence.
  // ****
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    general_chip_selects = 8'hC3;
    irq = 4'h9;
    {s1Tx, s1Rx, s1RxOe, s0Tx, s0Rx, s0RxOe} = 6'b101010;
    extVal2 = 8'h00;
    extEn2 = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(4'h0, 16'h00FF);
    rc(4'h4, 16'h00FF);
    rc(4'h8, 16'h000F);
    for (int p = 0; p < 3; p++) begin
      rc(4'(4 * p + 1), (p == 2) ? 16'h003F : 16'h00FF);
    end
    chk(p1PadOut, general_chip_selects);
    chk(p3PadOe[5:4], 2'b00);
    chk(p3PadOut[3:0], irq);
    chk(p2PadOe, 8'h32);
    chk({p2PadOut[5:4], p2PadOut[1]}, {s1Tx, s1Rx, s0Tx});
    rc(4'hB, 16'h0039);
    $display("reset test done");
    wr(4'h2, 16'h005A);
    wr(4'h0, 16'h0000);
    chk(p1PadOut, 8'h5A);
    wr(4'h1, 16'h0000);
    chk(p1PadOe, 8'hFF);
    rc(4'h1, 16'h0000);
    wr(4'h0, 16'h00F0);
    chk(p1PadOut, {general_chip_selects[7:4], 4'hA});
    rc(4'h2, 16'h005A);
    settle();
    rc(4'h3, 16'h00CA);
    $display("port 1 test done");
    wr(4'h6, 16'h00A5);
    wr(4'h5, 16'h000F);
    wr(4'h4, 16'h0000);
    chk(p2PadOe, 8'hF0);
    chk(p2PadOut[7:4], 4'hA);
    @(posedge clk);
    extVal2 <= 8'h03;
    extEn2 <= 8'h0F;
    settle();
    rc(4'h7, 16'h00A3);
    wr(4'h7, 16'h0000);
    rc(4'h6, 16'h00A5);
    rc(4'h7, 16'h00A3);
    chk({s0Cts, s0Bclk, s0RxIn}, 3'b001);
    chk({s1Cts, s1Bclk, s1RxIn}, 3'b100);
    wr(4'h4, 16'h00FF);
    chk(p2PadOe, 8'h32);
    @(posedge clk);
    s0RxOe <= 1'b1;
    @(posedge clk);
    #1;
    chk(p2PadOe, 8'h33);
    $display("port 2 test done");
    wr(4'hA, 16'h0025);
    wr(4'h9, 16'h0000);
    wr(4'h8, 16'h0000);
    chk(p3PadOe[5:4], 2'b01);
    chk(p3PadOut[3:0], 4'h5);
    settle();
    rc(4'hB, 16'h0025);
    wr(4'h9, 16'h0010);
    chk(p3PadOe[5:4], 2'b00);
    wr(4'h9, 16'h0000);
    wr(4'h8, 16'h0030);
    chk(p3PadOe[5:4], 2'b00);
    wr(4'h8, 16'h000F);
    @(posedge clk);
    irq <= 4'h6;
    @(posedge clk);
    #1;
    chk(p3PadOut[3:0], 4'h6);
    $display("port 3 test done");
    wr(4'hC, 16'hFFFF);
    rc(4'hC, 16'h0000);
    rc(4'hF, 16'h0000);
    // A write while the clock enable is low must leave the latch untouched.
    @(posedge clk);
    clkEn <= 1'b0;
    wr(4'h2, 16'h00FF);
    @(posedge clk);
    clkEn <= 1'b1;
    rc(4'h2, 16'h005A);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rc(4'h8, 16'h000F);
    $display("refusal and reset test done");
    complete_run();
  end
endmodule

/* verilog/mioprt_pin_cell.sv */
// One port pin cell: source muxing, driver control and input synchroniser.
`timescale 1ns/10ps

module mioprt_pin_cell
  import mioprt_pkg::*;
#(
  parameter mioprt_kind_e KIND = MIOPRT_BIDIR
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Programming bits.
  input wire logic funcSel,
  input wire logic dirBit,
  input wire logic latchBit,
  // Peripheral side.
  input wire logic periphOut,
  input wire logic periphOe,
  // Pad side.
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  // Synchronised pin level.
  output logic pinLevel
);

  logic sync1_q;
  logic sync2_q;

  // Driver selection; the enable is combinational from the programming bits and the peripheral enable.
  always_comb begin
    case (KIND)
      MIOPRT_OUTONLY: begin
        padOe = 1'b1;
        padOut = funcSel ? periphOut : latchBit;
      end
      MIOPRT_OPENDRAIN: begin
        // Only a low is ever driven; a missing peripheral leaves the pin floating.
        padOut = 1'b0;
        padOe = !funcSel && !dirBit && !latchBit;
      end
      default: begin
        padOut = funcSel ? periphOut : latchBit;
        padOe = funcSel ? periphOe : !dirBit;
      end
    endcase
  end

  // Two-stage synchroniser; only the second stage is read outside.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (clkEn) begin
      sync1_q <= padIn;
      sync2_q <= sync1_q;
    end
  end

  assign pinLevel = sync2_q;

endmodule

/* verilog/mioprt_pkg.sv */
// Types shared by the multiplexed I/O port unit.
package mioprt_pkg;

  // Kind of pin built from the common port cell.
  typedef enum logic [1:0] {
    MIOPRT_BIDIR = 2'b00,
    MIOPRT_OUTONLY = 2'b01,
    MIOPRT_OPENDRAIN = 2'b10
  } mioprt_kind_e;

endpackage

/* verilog/mioprt_port_unit.sv */
// Top of the multiplexed I/O port unit: three ports, their registers and the pin cells.
//
// Function
// - Function select peripheral: peripheral drives data and enable; port: software controls.
// - Bidirectional port pin: direction clear drives output, direction set makes input.
// - Output port pin drives its data latch bit.
// - Each pin level is synchronised and readable at any time.
// - Output-only pins always drive; select picks source; direction bit is storage.
// - Open-drain output: latch zero pulls low, latch one floats.
// - Open-drain direction bit set floats the pin regardless of latch.
// - Open-drain pin with peripheral selected floats.
// - Port 1 is eight output-only pins shared with chip selects.
// - Port 2 is eight bidirectional pins carrying two serial channels.
// - Port 3: bits 0-3 output-only interrupt requests, bits 4-5 open-drain.
// - Each port has function select, direction, data latch and pin state registers.
// - Direction register reads return the value last written.
// - Peripheral-owned pins take direction from the peripheral, ignoring direction bit.
// - Direction field eight bits resetting to ones; Port 3 lacks bits 7 and 6.
// - Data latch reads return the latch, not the pin.
// - Pin state register is read-only and returns current pin levels.
// - After reset peripheral functions selected; Port 3 bits 4-5 float.
`timescale 1ns/10ps

`include "mioprt_regs.svh"

module mioprt_port_unit
  import mioprt_pkg::*;
#(
  parameter int P1_W = 8,
  parameter int P2_W = 8,
  parameter int P3_W = 6
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Register port.
  input wire logic [`MIOPRT_ADDR_W-1:0] regAddr,
  input wire logic [`MIOPRT_DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [`MIOPRT_DATA_W-1:0] regRdData,
  // Port 1 peripheral side: general chip selects.
  input wire logic [7:0] general_chip_selects,
  // Port 2 peripheral side: serial channel 1.
  output logic serial1_clear_to_send,
  output logic serial1_baud_clock_in,
  input wire logic serial1_transmit_line,
  input wire logic serial1_receive_line,
  input wire logic serial1RxOe,
  output logic serial1RxIn,
  // Port 2 peripheral side: serial channel 0.
  output logic serial0_clear_to_send,
  output logic serial0_baud_clock_in,
  input wire logic serial0_transmit_line,
  input wire logic serial0_receive_line,
  input wire logic serial0RxOe,
  output logic serial0RxIn,
  // Port 3 peripheral side: interrupt requests.
  input wire logic serial1_receive_interrupt,
  input wire logic serial1_transmit_interrupt,
  input wire logic dma0_interrupt_request,
  input wire logic dma1_interrupt_request,
  // Port 1 pads.
  input wire logic [P1_W-1:0] p1PadIn,
  output logic [P1_W-1:0] p1PadOut,
  output logic [P1_W-1:0] p1PadOe,
  // Port 2 pads.
  input wire logic [P2_W-1:0] p2PadIn,
  output logic [P2_W-1:0] p2PadOut,
  output logic [P2_W-1:0] p2PadOe,
  // Port 3 pads.
  input wire logic [P3_W-1:0] p3PadIn,
  output logic [P3_W-1:0] p3PadOut,
  output logic [P3_W-1:0] p3PadOe
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [P1_W-1:0] p1Func_q;
  logic [P1_W-1:0] p1Dir_q;
  logic [P1_W-1:0] p1Latch_q;
  logic [P2_W-1:0] p2Func_q;
  logic [P2_W-1:0] p2Dir_q;
  logic [P2_W-1:0] p2Latch_q;
  logic [P3_W-1:0] p3Func_q;
  logic [P3_W-1:0] p3Dir_q;
  logic [P3_W-1:0] p3Latch_q;
  logic [P1_W-1:0] p1Level;
  logic [P2_W-1:0] p2Level;
  logic [P3_W-1:0] p3Level;
  logic [P2_W-1:0] p2PeriphOut;
  logic [P2_W-1:0] p2PeriphOe;
  logic [P3_W-1:0] p3PeriphOut;
  logic [`MIOPRT_DATA_W-1:0] rdData_d;
  logic [`MIOPRT_DATA_W-1:0] rdData_q;

  // Function select registers; reset chooses the peripheral side everywhere but the open-drain pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      p1Func_q <= P1_W'(`MIOPRT_P1_FUNC_RST);
      p2Func_q <= P2_W'(`MIOPRT_P2_FUNC_RST);
      p3Func_q <= P3_W'(`MIOPRT_P3_FUNC_RST);
    end else if (clkEn && regWrEn) begin
      case (regAddr)
        `MIOPRT_P1_FUNC: p1Func_q <= regWrData[P1_W-1:0];
        `MIOPRT_P2_FUNC: p2Func_q <= regWrData[P2_W-1:0];
        `MIOPRT_P3_FUNC: p3Func_q <= regWrData[P3_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Direction registers; Port 3 stores only its six bits, so writes to the top ones are dropped and they read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      p1Dir_q <= P1_W'(`MIOPRT_DIR_RST);
      p2Dir_q <= P2_W'(`MIOPRT_DIR_RST);
      p3Dir_q <= P3_W'(`MIOPRT_DIR_RST);
    end else if (clkEn && regWrEn) begin
      case (regAddr)
        `MIOPRT_P1_DIR: p1Dir_q <= regWrData[P1_W-1:0];
        `MIOPRT_P2_DIR: p2Dir_q <= regWrData[P2_W-1:0];
        `MIOPRT_P3_DIR: p3Dir_q <= regWrData[P3_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Data latch registers; program these before switching a pin to port output.
  always_ff @(posedge clk) begin
    if (rst) begin
      p1Latch_q <= P1_W'(`MIOPRT_LATCH_RST);
      p2Latch_q <= P2_W'(`MIOPRT_LATCH_RST);
      p3Latch_q <= P3_W'(`MIOPRT_LATCH_RST);
    end else if (clkEn && regWrEn) begin
      case (regAddr)
        `MIOPRT_P1_LATCH: p1Latch_q <= regWrData[P1_W-1:0];
        `MIOPRT_P2_LATCH: p2Latch_q <= regWrData[P2_W-1:0];
        `MIOPRT_P3_LATCH: p3Latch_q <= regWrData[P3_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read mux; pin state registers ignore writes and unmapped offsets read zero.
  always_comb begin
    rdData_d = '0;
    case (regAddr)
      `MIOPRT_P1_FUNC: rdData_d[P1_W-1:0] = p1Func_q;
      `MIOPRT_P1_DIR: rdData_d[P1_W-1:0] = p1Dir_q;
      `MIOPRT_P1_LATCH: rdData_d[P1_W-1:0] = p1Latch_q;
      `MIOPRT_P1_PIN: rdData_d[P1_W-1:0] = p1Level;
      `MIOPRT_P2_FUNC: rdData_d[P2_W-1:0] = p2Func_q;
      `MIOPRT_P2_DIR: rdData_d[P2_W-1:0] = p2Dir_q;
      `MIOPRT_P2_LATCH: rdData_d[P2_W-1:0] = p2Latch_q;
      `MIOPRT_P2_PIN: rdData_d[P2_W-1:0] = p2Level;
      `MIOPRT_P3_FUNC: rdData_d[P3_W-1:0] = p3Func_q;
      `MIOPRT_P3_DIR: rdData_d[P3_W-1:0] = p3Dir_q;
      `MIOPRT_P3_LATCH: rdData_d[P3_W-1:0] = p3Latch_q;
      `MIOPRT_P3_PIN: rdData_d[P3_W-1:0] = p3Level;
      default: rdData_d = '0;
    endcase
  end

  // Read data register; it holds its value only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (clkEn) begin
      rdData_q <= regRdEn ? rdData_d : '0;
    end
  end

  assign regRdData = rdData_q;

  // ****************************************************************
  // Peripheral routing
  // ****************************************************************
  // Port 2 order per channel from top bit: clear-to-send, baud clock, transmit, receive.
  assign p2PeriphOut = {1'b0, 1'b0, serial1_transmit_line, serial1_receive_line,
                        1'b0, 1'b0, serial0_transmit_line, serial0_receive_line};
  // Inputs never drive, transmit always drives, receive follows its channel.
  assign p2PeriphOe = {1'b0, 1'b0, 1'b1, serial1RxOe, 1'b0, 1'b0, 1'b1, serial0RxOe};
  // Synchronised levels feed the serial inputs whatever the pin mode.
  assign serial1_clear_to_send = p2Level[7];
  assign serial1_baud_clock_in = p2Level[6];
  assign serial1RxIn = p2Level[4];
  assign serial0_clear_to_send = p2Level[3];
  assign serial0_baud_clock_in = p2Level[2];
  assign serial0RxIn = p2Level[0];
  // Port 3 low bits carry interrupt requests; the open-drain bits have no peripheral.
  assign p3PeriphOut = {2'b00, dma1_interrupt_request, dma0_interrupt_request,
                        serial1_transmit_interrupt, serial1_receive_interrupt};

  // ****************************************************************
  // Pin cells
  // ****************************************************************
  genvar gi;
  generate
    // Port 1: output-only chip select pins.
    for (gi = 0; gi < P1_W; gi++) begin : gP1
      mioprt_pin_cell #(.KIND(MIOPRT_OUTONLY)) uCell (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .funcSel(p1Func_q[gi]),
        .dirBit(p1Dir_q[gi]),
        .latchBit(p1Latch_q[gi]),
        .periphOut(general_chip_selects[gi]),
        .periphOe(1'b1),
        .padIn(p1PadIn[gi]),
        .padOut(p1PadOut[gi]),
        .padOe(p1PadOe[gi]),
        .pinLevel(p1Level[gi])
      );
    end
    // Port 2: bidirectional serial pins.
    for (gi = 0; gi < P2_W; gi++) begin : gP2
      mioprt_pin_cell #(.KIND(MIOPRT_BIDIR)) uCell (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .funcSel(p2Func_q[gi]),
        .dirBit(p2Dir_q[gi]),
        .latchBit(p2Latch_q[gi]),
        .periphOut(p2PeriphOut[gi]),
        .periphOe(p2PeriphOe[gi]),
        .padIn(p2PadIn[gi]),
        .padOut(p2PadOut[gi]),
        .padOe(p2PadOe[gi]),
        .pinLevel(p2Level[gi])
      );
    end
    // Port 3: four output-only pins, then open-drain pins above them.
    for (gi = 0; gi < P3_W; gi++) begin : gP3
      mioprt_pin_cell #(.KIND(gi < 4 ? MIOPRT_OUTONLY : MIOPRT_OPENDRAIN)) uCell (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .funcSel(p3Func_q[gi]),
        .dirBit(p3Dir_q[gi]),
        .latchBit(p3Latch_q[gi]),
        .periphOut(p3PeriphOut[gi]),
        .periphOe(1'b1),
        .padIn(p3PadIn[gi]),
        .padOut(p3PadOut[gi]),
        .padOe(p3PadOe[gi]),
        .pinLevel(p3Level[gi])
      );
    end
  endgenerate

endmodule

/* verilog/mioprt_regs.svh */
// Register offsets, field widths and reset values of the multiplexed I/O port unit.
`ifndef MIOPRT_REGS_SVH
`define MIOPRT_REGS_SVH

// ****************************************************************
// Register offsets (word index on the plain register port)
// ****************************************************************
`define MIOPRT_ADDR_W 4
`define MIOPRT_P1_FUNC 4'h0
`define MIOPRT_P1_DIR 4'h1
`define MIOPRT_P1_LATCH 4'h2
`define MIOPRT_P1_PIN 4'h3
`define MIOPRT_P2_FUNC 4'h4
`define MIOPRT_P2_DIR 4'h5
`define MIOPRT_P2_LATCH 4'h6
`define MIOPRT_P2_PIN 4'h7
`define MIOPRT_P3_FUNC 4'h8
`define MIOPRT_P3_DIR 4'h9
`define MIOPRT_P3_LATCH 4'hA
`define MIOPRT_P3_PIN 4'hB

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define MIOPRT_DATA_W 16
`define MIOPRT_P1_FUNC_RST 8'hFF
`define MIOPRT_P2_FUNC_RST 8'hFF
`define MIOPRT_P3_FUNC_RST 6'h0F
`define MIOPRT_DIR_RST 8'hFF
`define MIOPRT_LATCH_RST 8'h00

`endif
